// ### shared/bitc_params.svh
// Offsets, field positions and line timing of the banked window
// and transmit controller.
// Assumes inclusion by bare name, from the package only.
`ifndef BITC_PARAMS_SVH
`define BITC_PARAMS_SVH
// ----------------------------------------
// Window layout
// ----------------------------------------
`define BITC_BASE_W     9
`define BITC_OFF_TXC    4'h0
`define BITC_OFF_STAT   4'h2
`define BITC_OFF_BANK   4'hE
`define BITC_BANK_TX    3'h0
`define BITC_BANK_EXT   3'h7
`define BITC_TXC_WMASK  16'hBD87
`define BITC_BANK_WMASK 8'h07
// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define BITC_ST_OK      0
`define BITC_ST_16COL   4
`define BITC_ST_SQE     5
`define BITC_ST_LATE    9
`define BITC_ST_LOST    10
// ----------------------------------------
// Line timing in bit times and bytes, retry limits, nibble codes and FCS constants
// ----------------------------------------
`define BITC_NIB_BITS   4
`define BITC_PRE_BITS   56
`define BITC_SFD_BITS   8
`define BITC_IFG_BITS   96
`define BITC_JAM_BITS   32
`define BITC_SLOT_BITS  512
`define BITC_LATE_BITS  512
`define BITC_FCS_BITS   32
`define BITC_MIN_FRAME  64
`define BITC_FCS_BYTES  4
`define BITC_MAX_TRIES  16
`define BITC_BO_CAP     10
`define BITC_PRE_NIB    4'h5
`define BITC_SFD_NIB    4'hD
`define BITC_JAM_NIB    4'h5
`define BITC_FCS_POLY   32'hEDB88320
`define BITC_FCS_INIT   32'hFFFFFFFF
`endif

// ### shared/bitc_pkg.sv
// Types of the banked window and transmit controller.
// Assumes bitc_params.svh is on the include path.
`include "bitc_params.svh"
package bitc_pkg;
  // ----------------------------------------
  // Byte lane selection
  // ----------------------------------------
  typedef enum logic [2:0] {
    BITC_SEL_NONE    = 3'h0,
    BITC_SEL_TXC_LO  = 3'h1,
    BITC_SEL_TXC_HI  = 3'h2,
    BITC_SEL_STAT_LO = 3'h3,
    BITC_SEL_STAT_HI = 3'h4,
    BITC_SEL_BANK_LO = 3'h5,
    BITC_SEL_BANK_HI = 3'h6
  } bitc_sel_e;

  typedef enum logic [2:0] {
    BITC_IDLE    = 3'h0,
    BITC_PRE     = 3'h1,
    BITC_DATA    = 3'h3,
    BITC_FCS     = 3'h2,
    BITC_IFG     = 3'h6,
    BITC_JAM     = 3'h7,
    BITC_BACKOFF = 3'h5
  } bitc_tx_e;

  typedef struct packed {
    logic       switched_full_duplex;
    logic       rsv14;
    logic       internal_loopback;
    logic       stop_on_sqe_error;
    logic       receive_own_frames;
    logic       carrier_monitor;
    logic       rsv9;
    logic       omit_fcs;
    logic       pad_enable;
    logic [3:0] rsv6_3;
    logic       force_collision;
    logic       phy_loop;
    logic       transmitter_on;
  } bitc_txc_s;

  typedef struct packed {
    logic        cs;
    logic        wr;
    logic [15:2] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } bitc_host_s;

  typedef struct packed {
    bitc_txc_s   transmit_control;
    logic [2:0]  bank;
    logic [31:0] rdata;
    logic        ack;
    bitc_tx_e    st;
    logic [16:0] cnt;
    logic [11:0] nidx;
    logic [4:0]  tries;
    logic [31:0] crc;
    logic [9:0]  lfsr;
    logic        pkt;
    logic        fcs_on;
    logic        col_pend;
    logic        retry;
    logic        chk_sqe;
    logic        sqe_seen;
    logic        crs_prev;
    logic        carrier_lost_flag;
    logic        late_collision_flag;
    logic        sqe_test_flag;
    logic        excess_col_flag;
    logic        tx_ok_flag;
    logic [3:0]  txd;
    logic        txv;
    logic [3:0]  lpd;
    logic        lpv;
    logic        rxdv;
    logic        rxer;
    logic        rxacc;
    logic        take;
    logic        done;
    logic        fail;
    logic        rewind;
  } bitc_top_s;

  // Byte offset within the window to register lane
  function automatic bitc_sel_e bitc_decode(logic [2:0] bank, logic [3:0] off);
    bitc_sel_e s;
    s = BITC_SEL_NONE;
    if ({off[3:1], 1'b0} == `BITC_OFF_BANK) begin
      s = off[0] ? BITC_SEL_BANK_HI : BITC_SEL_BANK_LO;
    end else if (bank == `BITC_BANK_TX) begin
      if ({off[3:1], 1'b0} == `BITC_OFF_TXC) begin
        s = off[0] ? BITC_SEL_TXC_HI : BITC_SEL_TXC_LO;
      end else if ({off[3:1], 1'b0} == `BITC_OFF_STAT) begin
        s = off[0] ? BITC_SEL_STAT_HI : BITC_SEL_STAT_LO;
      end
    end
    return s;
  endfunction : bitc_decode
endpackage : bitc_pkg

// ### hw/bitc_fcs.sv
// Frame check sequence update over one nibble, low bit first.
// Assumes a reflected register preset by the caller.
`timescale 1ns/1ps
`default_nettype none
module bitc_fcs
  import bitc_pkg::*;
(
  // Running value
  input  wire logic [31:0] crc_in,
  input  wire logic [3:0]  nib,
  // Updated value
  output logic      [31:0] crc_out
);
  always_comb begin
    crc_out = crc_in;
    for (int k = 0; k < 4; k++) begin
      if (crc_out[0] ^ nib[k]) begin
        crc_out = (crc_out >> 1) ^ `BITC_FCS_POLY;
      end else begin
        crc_out = crc_out >> 1;
      end
    end
  end
endmodule : bitc_fcs
`default_nettype wire

// ### hw/bitc_host_lanes.sv
// Window hit, per-lane register decode and external chip select.
// Assumes host requests are synchronous to the controller clock.
`timescale 1ns/1ps
`default_nettype none
module bitc_host_lanes
  import bitc_pkg::*;
(
  // Request and placement
  input  wire bitc_host_s             host_req,
  input  wire logic [2:0]             bank,
  input  wire logic [2:0]             base_select_pins,
  input  wire logic [`BITC_BASE_W-1:0] cfg_base,
  // Decode
  output var  bitc_sel_e [3:0]        lane_sel,
  output logic                        hit,
  output logic                        ext_reg_chip_select_n
);
  assign hit = host_req.cs
             & (host_req.addr[15:4] == {cfg_base, base_select_pins});

  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign lane_sel[i] = hit ? bitc_decode(bank, {host_req.addr[3:2], 2'(i)})
                             : BITC_SEL_NONE;
  end

  assign ext_reg_chip_select_n = ~(hit & (bank == `BITC_BANK_EXT)
                                   & ~host_req.addr[3]);
endmodule : bitc_host_lanes
`default_nettype wire

// ### hw/bitc_top.sv
// Banked host register window with the transmit control register
// and the nibble transmitter it steers.
// Assumes one nibble time per clock and a packet buffer that holds
// the current byte on pkt_byte until pkt_take.
`timescale 1ns/1ps
`default_nettype none
module bitc_top
  import bitc_pkg::*;
#(
  parameter int         LEN_W   = 11,
  parameter logic [7:0] BANK_ID = 8'h5A  // Arbitrary identity value
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    nrst,
  // Host bus
  input  wire bitc_host_s              host_req,
  output logic      [31:0]             host_rdata,
  output logic                         host_ack,
  // Window placement
  input  wire logic [2:0]              base_select_pins,
  input  wire logic [`BITC_BASE_W-1:0] cfg_base,
  output logic                         ext_reg_chip_select_n,
  // Packet buffer
  input  wire logic                    pkt_valid,
  input  wire logic [LEN_W-1:0]        pkt_len,
  input  wire logic                    pkt_fcs,
  input  wire logic [7:0]              pkt_byte,
  output logic                         pkt_take,
  output logic                         pkt_rewind,
  output logic                         pkt_done,
  output logic                         pkt_fail,
  // Media interface
  input  wire logic                    carrier_sense_input,
  input  wire logic                    collision_input,
  input  wire logic                    sqe_heartbeat,
  output logic      [3:0]              transmit_nibble_output,
  output logic                         transmit_valid_output,
  output logic                         phy_loopback_pin,
  // Receive side gating
  input  wire logic                    rx_dv_in,
  input  wire logic                    rx_er_in,
  input  wire logic                    rx_addr_pass,
  input  wire logic                    rx_self_src,
  output logic                         rx_dv_gated,
  output logic                         rx_er_gated,
  output logic                         rx_accept,
  output logic      [3:0]              loop_nibble,
  output logic                         loop_valid
);
  // ----------------------------------------
  // Counts in nibble clocks and bytes, retry limits and write masks
  // ----------------------------------------
  localparam logic [16:0] PRE_N  = 17'(`BITC_PRE_BITS / `BITC_NIB_BITS);
  localparam logic [16:0] SFD_N  = 17'(`BITC_SFD_BITS / `BITC_NIB_BITS);
  localparam logic [16:0] IFG_N  = 17'(`BITC_IFG_BITS / `BITC_NIB_BITS);
  localparam logic [16:0] JAM_N  = 17'(`BITC_JAM_BITS / `BITC_NIB_BITS);
  localparam logic [16:0] FCS_N  = 17'(`BITC_FCS_BITS / `BITC_NIB_BITS);
  localparam logic [16:0] SLOT_N = 17'(`BITC_SLOT_BITS / `BITC_NIB_BITS);
  localparam logic [11:0] LATE_N = 12'(`BITC_LATE_BITS / `BITC_NIB_BITS);
  localparam logic [LEN_W-1:0] PAD_B =
    LEN_W'(`BITC_MIN_FRAME - `BITC_FCS_BYTES);
  localparam logic [4:0]  MAXT   = 5'(`BITC_MAX_TRIES - 1);
  localparam logic [4:0]  BOCAP  = 5'(`BITC_BO_CAP);
  localparam logic [15:0] WMASK  = `BITC_TXC_WMASK;
  localparam logic [7:0]  BMASK  = `BITC_BANK_WMASK;

  bitc_top_s        s_r;
  bitc_top_s        s_nxt;
  bitc_sel_e [3:0]  lane_sel;
  logic             hit;
  logic      [31:0] fcs_nxt;
  logic      [15:0] stat;
  logic      [7:0]  wb;
  logic      [7:0]  cur_byte;
  logic      [3:0]  nib;
  logic      [LEN_W-1:0] bidx;
  logic      [LEN_W-1:0] nb;
  logic      [4:0]  bo_exp;
  logic      [9:0]  bo_r;
  logic             drive;
  logic             crs;
  logic             col;
  logic             half;
  logic             mon;
  logic             last;
  logic             kill;
  logic             clr;
  logic             fin;
  logic             lost;
  logic             in_frame;

  bitc_host_lanes u_lanes (
    .host_req              (host_req),
    .bank                  (s_r.bank),
    .base_select_pins      (base_select_pins),
    .cfg_base              (cfg_base),
    .lane_sel              (lane_sel),
    .hit                   (hit),
    .ext_reg_chip_select_n (ext_reg_chip_select_n)
  );

  bitc_fcs u_fcs (
    .crc_in  (s_r.crc),
    .nib     (nib),
    .crc_out (fcs_nxt)
  );

  // ----------------------------------------
  // Read lane mux
  // ----------------------------------------
  function automatic logic [7:0] rd_byte(bitc_sel_e sl, logic [15:0] txc,
                                         logic [15:0] st, logic [2:0] bk);
    case (sl)
      BITC_SEL_TXC_LO:  rd_byte = txc[7:0];
      BITC_SEL_TXC_HI:  rd_byte = txc[15:8];
      BITC_SEL_STAT_LO: rd_byte = st[7:0];
      BITC_SEL_STAT_HI: rd_byte = st[15:8];
      BITC_SEL_BANK_LO: rd_byte = {5'h00, bk};
      BITC_SEL_BANK_HI: rd_byte = BANK_ID;
      default:          rd_byte = 8'h00;
    endcase
  endfunction : rd_byte

  always_comb begin
    s_nxt    = s_r;
    stat     = 16'h0000;
    wb       = 8'h00;
    nib      = 4'h0;
    drive    = 1'b0;
    last     = 1'b0;
    kill     = 1'b0;
    clr      = 1'b0;
    fin      = 1'b0;
    lost     = 1'b0;
    bo_exp   = 5'h00;
    bo_r     = 10'h000;
    bidx     = s_r.cnt[LEN_W:1];
    nb       = bidx + 1'b1;
    cur_byte = (bidx < pkt_len) ? pkt_byte : 8'h00;
    in_frame = (s_r.st == BITC_PRE) | (s_r.st == BITC_DATA)
             | (s_r.st == BITC_FCS);
    crs  = carrier_sense_input & ~s_r.transmit_control.internal_loopback;
    col  = collision_input & ~s_r.transmit_control.internal_loopback;
    // Carrier monitor void in switched duplex
    half = ~s_r.transmit_control.switched_full_duplex;
    mon  = s_r.transmit_control.carrier_monitor & half;
    s_nxt.take     = 1'b0;
    s_nxt.done     = 1'b0;
    s_nxt.fail     = 1'b0;
    s_nxt.rewind   = 1'b0;
    s_nxt.ack      = 1'b0;
    s_nxt.crs_prev = crs;
    s_nxt.lfsr     = {s_r.lfsr[8:0], ~(s_r.lfsr[9] ^ s_r.lfsr[6])};

    stat[`BITC_ST_OK]    = s_r.tx_ok_flag;
    stat[`BITC_ST_16COL] = s_r.excess_col_flag;
    stat[`BITC_ST_SQE]   = s_r.sqe_test_flag;
    stat[`BITC_ST_LATE]  = s_r.late_collision_flag;
    stat[`BITC_ST_LOST]  = s_r.carrier_lost_flag;

    // ----------------------------------------
    // Host access
    // ----------------------------------------
    if (hit) begin
      s_nxt.ack = 1'b1;
      for (int i = 0; i < 4; i++) begin
        s_nxt.rdata[8*i +: 8] = host_req.be[i]
          ? rd_byte(lane_sel[i], s_r.transmit_control, stat, s_r.bank)
          : 8'h00;
      end
    end
    // Lanes outside a register are dropped
    for (int i = 0; i < 4; i++) begin
      if (hit & host_req.wr & host_req.be[i]) begin
        wb = host_req.wdata[8*i +: 8];
        case (lane_sel[i])
          BITC_SEL_TXC_LO: begin
            s_nxt.transmit_control[7:0] = wb & WMASK[7:0];
            clr = wb[0];
          end
          BITC_SEL_TXC_HI: s_nxt.transmit_control[15:8] = wb & WMASK[15:8];
          BITC_SEL_BANK_LO: s_nxt.bank = 3'(wb & BMASK);
          default: ;
        endcase
      end
    end
    // Enabling the transmitter clears the error history
    if (clr) begin
      s_nxt.carrier_lost_flag   = 1'b0;
      s_nxt.late_collision_flag = 1'b0;
      s_nxt.sqe_test_flag       = 1'b0;
      s_nxt.excess_col_flag     = 1'b0;
      s_nxt.tx_ok_flag          = 1'b0;
    end

    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    case (s_r.st)
      BITC_IDLE: begin
        if (s_r.transmit_control.transmitter_on
            & (s_r.transmit_control.force_collision ? (crs & ~s_r.crs_prev)
                                                    : pkt_valid & (~crs | ~half))) begin
          s_nxt.st       = BITC_PRE;
          s_nxt.cnt      = 17'h00000;
          s_nxt.nidx     = 12'h000;
          s_nxt.pkt      = pkt_valid;
          s_nxt.crc      = `BITC_FCS_INIT;
          s_nxt.col_pend = 1'b0;
          s_nxt.retry    = 1'b0;
          s_nxt.tx_ok_flag = 1'b0;
          s_nxt.fcs_on   = ~s_r.transmit_control.omit_fcs | pkt_fcs;
        end
      end
      BITC_PRE: begin
        drive = 1'b1;
        nib   = (s_r.cnt == PRE_N + SFD_N - 17'h1) ? `BITC_SFD_NIB : `BITC_PRE_NIB;
        last  = s_r.pkt ? (s_r.cnt == PRE_N + SFD_N - 17'h1)
                        : (s_r.cnt == PRE_N - 17'h1);
        s_nxt.cnt = s_r.cnt + 17'h1;
        if (col & ~half) s_nxt.col_pend = 1'b1;
        if (last) begin
          s_nxt.cnt = 17'h00000;
          if (s_r.col_pend | (col & ~half)) begin
            s_nxt.st    = BITC_JAM;
            s_nxt.retry = 1'b1;
          end else if (mon & ~crs) begin
            lost = 1'b1;
          end else begin
            s_nxt.st = s_r.pkt ? BITC_DATA : BITC_IFG;
          end
        end
      end
      BITC_DATA: begin
        drive      = 1'b1;
        nib        = s_r.cnt[0] ? cur_byte[7:4] : cur_byte[3:0];
        s_nxt.crc  = fcs_nxt;
        s_nxt.take = s_r.cnt[0] & (bidx < pkt_len);
        s_nxt.cnt  = s_r.cnt + 17'h1;
        s_nxt.nidx = s_r.nidx + 12'h1;
        lost       = mon & ~crs;
        // Zero bytes up to minimum length
        if (s_r.cnt[0] & (nb >= pkt_len)
            & ~(s_r.transmit_control.pad_enable & (nb < PAD_B))) begin
          s_nxt.cnt = 17'h00000;
          if (s_r.fcs_on) s_nxt.st = BITC_FCS;
          else fin = 1'b1;
        end
      end
      BITC_FCS: begin
        drive      = 1'b1;
        nib        = ~s_r.crc[3:0];
        s_nxt.crc  = s_r.crc >> 4;
        s_nxt.cnt  = s_r.cnt + 17'h1;
        s_nxt.nidx = s_r.nidx + 12'h1;
        lost       = mon & ~crs;
        fin        = (s_r.cnt == FCS_N - 17'h1);
      end
      BITC_JAM: begin
        drive     = 1'b1;
        nib       = `BITC_JAM_NIB;
        s_nxt.cnt = s_r.cnt + 17'h1;
        if (s_r.cnt == (half ? JAM_N - 17'h1 : 17'h00000)) begin
          bo_exp    = (s_r.tries > BOCAP) ? BOCAP : s_r.tries;
          bo_r      = s_r.lfsr & ~(10'h3FF << bo_exp);
          s_nxt.cnt = half ? 17'(17'(bo_r) * SLOT_N) : 17'h00000;
          s_nxt.st  = s_r.retry ? BITC_BACKOFF : BITC_IFG;
          if (!s_r.retry) s_nxt.cnt = 17'h00000;
        end
      end
      BITC_BACKOFF: begin
        s_nxt.cnt = s_r.cnt - 17'h1;
        if (s_r.cnt == 17'h00000) begin
          s_nxt.st     = BITC_IFG;
          s_nxt.rewind = 1'b1;
        end
      end
      BITC_IFG: begin
        s_nxt.cnt      = s_r.cnt + 17'h1;
        s_nxt.sqe_seen = s_r.sqe_seen | sqe_heartbeat;
        if (s_r.cnt == IFG_N - 17'h1) begin
          s_nxt.st = BITC_IDLE;
          if (s_r.chk_sqe & ~(s_r.sqe_seen | sqe_heartbeat)) begin
            s_nxt.sqe_test_flag = 1'b1;
            kill = s_r.transmit_control.stop_on_sqe_error;
          end
          s_nxt.chk_sqe = 1'b0;
        end
      end
      default: s_nxt.st = BITC_IDLE;
    endcase

    if (fin) begin
      s_nxt.st         = BITC_IFG;
      s_nxt.cnt        = 17'h00000;
      s_nxt.done       = 1'b1;
      s_nxt.tx_ok_flag = 1'b1;
      s_nxt.tries      = 5'h00;
      s_nxt.sqe_seen   = 1'b0;
      s_nxt.chk_sqe    = half;
    end
    if (lost) begin
      drive = 1'b0;
      kill  = 1'b1;
      s_nxt.st   = BITC_IFG;
      s_nxt.cnt  = 17'h00000;
      s_nxt.done = 1'b0;
      s_nxt.fail = 1'b1;
      s_nxt.tx_ok_flag        = 1'b0;
      s_nxt.chk_sqe           = 1'b0;
      s_nxt.tries             = 5'h00;
      s_nxt.carrier_lost_flag = 1'b1;
    end
    if (col & ~half & ((s_r.st == BITC_DATA) | (s_r.st == BITC_FCS))) begin
      s_nxt.st    = BITC_JAM;
      s_nxt.cnt   = 17'h00000;
      s_nxt.retry = 1'b1;
      s_nxt.done  = 1'b0;
      s_nxt.tx_ok_flag = 1'b0;
    end
    if (col & half & in_frame) begin
      s_nxt.st   = BITC_JAM;
      s_nxt.cnt  = 17'h00000;
      s_nxt.done = 1'b0;
      s_nxt.tx_ok_flag = 1'b0;
      if (s_r.transmit_control.force_collision | (s_r.nidx >= LATE_N)) begin
        kill = 1'b1;
        s_nxt.fail  = 1'b1;
        s_nxt.retry = 1'b0;
        s_nxt.tries = 5'h00;
        s_nxt.late_collision_flag = 1'b1;
      end else if (s_r.tries == MAXT) begin
        kill = 1'b1;
        s_nxt.fail  = 1'b1;
        s_nxt.retry = 1'b0;
        s_nxt.tries = 5'h00;
        s_nxt.excess_col_flag = 1'b1;
      end else begin
        s_nxt.tries = s_r.tries + 5'h01;
        s_nxt.retry = 1'b1;
      end
    end
    if (kill) s_nxt.transmit_control.transmitter_on = 1'b0;

    s_nxt.txd = s_r.transmit_control.internal_loopback ? 4'h0 : nib;
    s_nxt.txv = drive & ~s_r.transmit_control.internal_loopback;
    s_nxt.lpd = nib;
    s_nxt.lpv = drive & s_r.transmit_control.internal_loopback;
    s_nxt.rxdv = rx_dv_in & ~s_r.transmit_control.internal_loopback;
    s_nxt.rxer = rx_er_in & ~s_r.transmit_control.internal_loopback;
    s_nxt.rxacc = rx_addr_pass & (~rx_self_src
                  | (s_r.transmit_control.receive_own_frames & half));
  end

  // Bank and control reset to zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign host_rdata             = s_r.rdata;
  assign host_ack               = s_r.ack;
  assign pkt_take               = s_r.take;
  assign pkt_rewind             = s_r.rewind;
  assign pkt_done               = s_r.done;
  assign pkt_fail               = s_r.fail;
  assign transmit_nibble_output = s_r.txd;
  assign transmit_valid_output  = s_r.txv;
  assign phy_loopback_pin       = s_r.transmit_control.phy_loop;
  assign rx_dv_gated            = s_r.rxdv;
  assign rx_er_gated            = s_r.rxer;
  assign rx_accept              = s_r.rxacc;
  assign loop_nibble            = s_r.lpd;
  assign loop_valid             = s_r.lpv;
endmodule : bitc_top
`default_nettype wire

// ### test/bitc_top_sva.sv
// Port assertions for the banked window.
// Assumes binding into bitc_top.
`timescale 1ns/1ps
`default_nettype none
module bitc_sva
  import bitc_pkg::*;
#(parameter logic [7:0] BANK_ID = 8'h5A) (
  input wire logic clk, nrst, host_ack,
  input wire bitc_host_s host_req,
  input wire logic [31:0] host_rdata,
  input wire logic [2:0] base_select_pins,
  input wire logic [8:0] cfg_base,
  input wire logic ext_reg_chip_select_n, transmit_valid_output, loop_valid,
  input wire logic [3:0] transmit_nibble_output,
  input wire logic rx_dv_gated, rx_accept, rx_addr_pass
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire logic hit = host_req.addr[15:4] == {cfg_base, base_select_pins};
  wire logic rd = host_req.cs & hit & !host_req.wr & (host_req.addr[3:2] == 2'h3);
  a_ack_one: assert property (host_req.cs && hit |=> host_ack)
    else $error("no ack after window access");
  a_ack_none: assert property (!(host_req.cs && hit) |=> !host_ack)
    else $error("ack without window access");
  a_ext_select: assert property (!ext_reg_chip_select_n |-> host_req.cs && hit && !host_req.addr[3])
    else $error("external select outside a low window access");
  a_sel_const: assert property (rd && host_req.be[3] |=> host_rdata[31:24] == BANK_ID)
    else $error("selector upper byte wrong");
  a_sel_zero: assert property (rd |=> host_rdata[23:19] == 5'h0 && host_rdata[15:0] == 16'h0)
    else $error("selector read lanes not zero");
  a_loop_quiet: assert property (loop_valid |-> !transmit_valid_output && transmit_nibble_output == 4'h0)
    else $error("pins active during internal loopback");
  a_loop_rx: assert property (loop_valid |-> !rx_dv_gated)
    else $error("receive valid passes in loopback");
  a_rx_accept: assert property (rx_accept |-> $past(rx_addr_pass))
    else $error("accept without filter pass");
endmodule : bitc_sva
bind bitc_top bitc_sva #(.BANK_ID(BANK_ID)) u_sva (.*);
`default_nettype wire

// ### test/bitc_pbuf.sv
// Packet buffer and shared carrier and collision line model.
// Assumes one queued packet per load pulse.
`timescale 1ns/1ps
`default_nettype none
module bitc_pbuf (
  input wire logic clk, nrst, load, line, pkt_take, pkt_rewind, pkt_done, pkt_fail,
  output logic pkt_valid, pkt_fcs, carrier_sense_input, collision_input, sqe_heartbeat,
  output logic [10:0] pkt_len,
  output logic [7:0] pkt_byte
);
  logic [7:0] idx;
  assign pkt_len = 11'h004;
  assign pkt_fcs = 1'b0;
  assign {carrier_sense_input, collision_input, sqe_heartbeat} = {line, line, 1'b0};
  // Next byte shows while take stands
  assign pkt_byte = pkt_valid ? idx + {7'h00, pkt_take} + 8'hA0 : ~idx;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pkt_valid <= 1'b0;
      idx <= 8'h00;
    end else begin
      if (load) pkt_valid <= 1'b1;
      if (pkt_done | pkt_fail) pkt_valid <= 1'b0;
      if (pkt_rewind | pkt_done | pkt_fail) idx <= 8'h00;
      else if (pkt_take) idx <= idx + 8'h01;
    end
  end
endmodule : bitc_pbuf
`default_nettype wire

// ### test/bitc_top_test.sv
// Self-checking bench for the banked window.
// Assumes the buffer model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module bitc_top_test
  import bitc_pkg::*;
;
  logic clk, nrst, load, line, x, rx_dv_in, rx_er_in, rx_addr_pass, rx_self_src, host_ack;
  bitc_host_s host_req;
  logic [2:0] base_select_pins;
  logic [8:0] cfg_base;
  logic [31:0] host_rdata, r, v;
  logic ext_reg_chip_select_n, pkt_valid, pkt_fcs, pkt_take, pkt_rewind, pkt_done;
  logic pkt_fail, carrier_sense_input, collision_input, sqe_heartbeat, loop_valid;
  logic transmit_valid_output, phy_loopback_pin, rx_dv_gated, rx_er_gated, rx_accept;
  logic [10:0] pkt_len;
  logic [7:0] pkt_byte;
  logic [3:0] transmit_nibble_output, loop_nibble;
  int miscompares, n_compared, cyc, n, q, t;
  bitc_top #(.BANK_ID(8'hC3)) dut (.*);  // Arbitrary identity value
  bitc_pbuf pbuf (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", s, e, g);
      miscompares++;
    end
  endtask : chk
  task automatic acc(logic w, logic [3:0] off, logic [3:0] be, logic [31:0] wd);
    @(posedge clk);
    host_req <= '{1'b1, w, {12'h52B, off[3:2]}, be, wd};
    #1 x = ext_reg_chip_select_n;
    @(posedge clk);
    host_req.cs <= 1'b0;
    #1 chk("ack", 1, host_ack);
    r = host_rdata;
  endtask : acc
  task automatic results;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  task automatic t_regs;
    acc(0, 4'hC, 4'hF, 0); chk("sel", 32'hC300_0000, r);
    acc(1, 4'h0, 4'h3, 32'hFFFF);
    acc(0, 4'h0, 4'hF, 0); chk("txc", 32'hBD87, r);
    chk("lbk", 1, phy_loopback_pin);
    acc(1, 4'h0, 4'h3, 0); chk("lbk", 0, phy_loopback_pin);
    @(posedge clk) host_req <= '{1'b1, 1'b0, 14'h0, 4'hF, 32'h0};
    @(posedge clk) host_req.cs <= 1'b0;
    #1 chk("miss", 0, host_ack);
    @(posedge clk) rx_self_src <= 1'b1;
    acc(1, 4'h0, 4'h3, 32'h0800);
    chk("own", 0, rx_accept);
    @(posedge clk) #1 chk("own", 1, rx_accept);
    $display("test regs done");
  endtask : t_regs
  task automatic t_bank;
    acc(1, 4'h0, 4'h1, 32'h80);
    acc(1, 4'hC, 4'hF, 32'hFF07_FFFF);
    acc(0, 4'h0, 4'hF, 0); chk("external_register_bank", 0, r);
    chk("csx", 0, x);
    acc(0, 4'hE, 4'h4, 0); chk("bsel", 32'h0007_0000, r);
    chk("csx", 1, x);
    acc(1, 4'hE, 4'h4, 0);
    acc(0, 4'h0, 4'h1, 0); chk("next", 32'h80, r);
    $display("test bank done");
  endtask : t_bank
  task automatic t_loop;
    acc(1, 4'h0, 4'h3, 32'h2081);  // Carrier monitor off
    @(posedge clk) load <= 1'b1;
    rx_dv_in <= 1'b1;
    rx_er_in <= 1'b1;
    @(posedge clk) load <= 1'b0;
    n = 0;
    q = 0;
    t = 0;
    for (int i = 0; i < 400 && pkt_done !== 1'b1; i++) begin
      @(posedge clk) #1;
      if (loop_valid === 1'b1 && n >= 14 && n < 22) v = {v[27:0], loop_nibble};
      n += (loop_valid === 1'b1);
      q += (transmit_valid_output !== 1'b0);
      t += (pkt_take === 1'b1);
    end
    chk("done", 1, pkt_done);
    chk("nibbles", 32'h90, n);
    chk("sfd data", 32'h5D0A_1A2A, v);
    chk("takes", 4, t);
    chk("quiet", 0, q);
    chk("rxdv", 0, rx_dv_gated);
    chk("rxer", 0, rx_er_gated);
    repeat (30) @(posedge clk);
    acc(1, 4'h0, 4'h3, 0);
    @(posedge clk) #1 chk("rxdv", 1, rx_dv_gated);
    chk("rxer", 1, rx_er_gated);
    $display("test loop done");
  endtask : t_loop
  task automatic t_fcol;
    acc(1, 4'h0, 4'h3, 32'h0005);
    @(posedge clk) load <= 1'b1;
    @(posedge clk) load <= 1'b0;
    line <= 1'b1;
    n = 0;
    q = 0;
    repeat (40) begin
      @(posedge clk) #1;
      n += (transmit_valid_output === 1'b1);
      q += (pkt_fail === 1'b1);
    end
    @(posedge clk) line <= 1'b0;
    // One preamble nibble, then eight jam nibbles
    chk("jam", 32'h9, n);
    chk("fail", 1, q);
    acc(0, 4'h0, 4'hF, 0); chk("late", 32'h0200_0004, r);
    $display("test fcol done");
  endtask : t_fcol
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    {nrst, load, line, rx_dv_in, rx_er_in, rx_self_src} = 6'h00;
    rx_addr_pass = 1'b1;
    host_req = '0;
    base_select_pins = 3'h3;
    cfg_base = 9'h0A5;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_bank();
    t_loop();
    t_fcol();
    results();
  end
endmodule : bitc_top_test
`default_nettype wire
